/* File: logic/gport_pkg.sv */
// Shared constants for the graphics port core-logic flow controller
package gport_pkg;
   localparam int BLOCK_BEATS = 4;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SHORT_READ_NS = 160;
   localparam int SHORT_READ_CYC = SHORT_READ_NS / CLK_PERIOD_NS;
   localparam logic [2:0] ST_LP_READ = 3'h0;
   localparam logic [2:0] ST_HP_READ = 3'h1;
   localparam logic [2:0] ST_LP_WRITE = 3'h2;
   localparam logic [2:0] ST_HP_WRITE = 3'h3;
   localparam logic [2:0] ST_START = 3'h7;
   localparam logic [2:0] ST_RESET = 3'h7;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_RD_BLOCK = 3'h1,
      S_RD_WAIT = 3'h2,
      S_WR_BLOCK = 3'h3,
      S_FW_BLOCK = 3'h4,
      S_FW_WAIT = 3'h5,
      S_FW_END = 3'h6
   } state_type;
endpackage

/* File: logic/gport_core_ctrl.sv */
// Core-logic (target/arbiter) end of the graphics port block flow control
// Function
// - Keep frame deasserted during pipelined transactions; frame only frames pushed writes.
// - Pipelined path never asserts stop or drives devsel; pushed writes use frame, stop, devsel.
// - No timing relation between frame and irdy in pipelined transactions.
// - Core drives irdy to mark valid pushed-write data.
// - Core inserts pushed-write wait states only between blocks.
// - Short read of four clocks or less gets trdy once.
// - Longer transfer gets trdy per block, initial and each subsequent.
// - Target waits only after a block, never inside one.
// - Keep stop deasserted during pipelined transactions.
// - No idsel, lock, intc or intd pins; none are used.
// - Status code meaningful only with grant; 000 read data, 111 start.
`timescale 1ns/1ps
`default_nettype none
module gport_core_ctrl #(
   parameter int BLOCKS_MAX = 8
) (
   input wire logic ref_clk, // Common bus clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic rdStart, // Pulse: begin pipelined read
   input wire logic wrStart, // Pulse: begin pipelined write
   input wire logic fwStart, // Pulse: begin pushed write
   input wire logic [3:0] xferBlocks, // Blocks in transfer, 1 = short
   input wire logic hiPriority, // Use high-priority status code
   input wire logic dataReady, // Core has next block available
   input wire logic irdyInN, // Master irdy pin
   input wire logic trdyInN, // Master trdy pin (pushed write)
   input wire logic stopInN, // Master stop pin (pushed write)
   input wire logic devselInN, // Master devsel pin (pushed write)
   input wire logic monitor_overcurrent_n, // Monitor supply overcurrent, low
   input wire logic pmeInN, // Power-management event pin
   output logic gntN, // Grant
   output logic [2:0] arbiter_status_code, // Status qualified by grant
   output logic frameOutN, // Frame pin value
   output logic frameOe, // Frame drive enable
   output logic irdyOutN, // Irdy pin value (pushed write)
   output logic irdyOe, // Irdy drive enable
   output logic trdyOutN, // Trdy pin value
   output logic trdyOe, // Trdy drive enable
   output logic stopOutN, // Stop pin value
   output logic stopOe, // Stop drive enable
   output logic pushed_write_mode, // Pushed write in progress
   output logic busy, // Transfer in progress
   output logic xferDone, // Pulse: transfer ended normally
   output logic xferAbort, // Pulse: target-abort or disconnect seen
   output logic retryError, // Pulse: illegal retry on pushed write
   output logic overcurrentEvent, // Pulse: overcurrent asserted
   output logic pmeSeen // Level: power event pin low
);
   initial begin
      if (BLOCKS_MAX < 1 || BLOCKS_MAX > 15) $error("BLOCKS_MAX out of range");
   end
   gport_pkg::state_type state_ff, nxt_state;
   logic [1:0] beat_ff, nxt_beat;
   logic [3:0] blk_ff, nxt_blk;
   logic [2:0] sync1_ff, sync2_ff;
   logic ovPrev_ff, first_ff, nxt_first;
   logic gnt_ff, nxt_gnt, frame_ff, nxt_frame, irdy_ff, nxt_irdy, trdy_ff, nxt_trdy;
   logic fw_ff, nxt_fw, done_ff, nxt_done, abort_ff, nxt_abort, retry_ff, nxt_retry;
   logic trdyOe_ff, nxt_trdyOe, fOe_ff, nxt_fOe;
   logic [2:0] st_ff, nxt_st;
   logic mIrdy, mTrdy, mStop, mDevsel;

   // Pins pass two flops before use
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= 3'h7;
         sync2_ff <= 3'h7;
         ovPrev_ff <= 1'b1;
      end else begin
         sync1_ff <= {monitor_overcurrent_n, pmeInN, 1'b1};
         sync2_ff <= sync1_ff;
         ovPrev_ff <= sync2_ff[2];
      end
   end
   // Falling edge of the overcurrent line is the event
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overcurrentEvent <= 1'b0;
         pmeSeen <= 1'b0;
      end else begin
         overcurrentEvent <= ovPrev_ff & ~sync2_ff[2];
         pmeSeen <= ~sync2_ff[1]; // Reported only, never steers flow
      end
   end

   // Only irdy, trdy, stop and devsel are sampled; no select or lock pins exist
   logic [3:0] ctl1_ff, ctl2_ff;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl1_ff <= 4'hF;
         ctl2_ff <= 4'hF;
      end else begin
         ctl1_ff <= {irdyInN, trdyInN, stopInN, devselInN};
         ctl2_ff <= ctl1_ff;
      end
   end
   assign mIrdy = ~ctl2_ff[3];
   assign mTrdy = ~ctl2_ff[2];
   assign mStop = ~ctl2_ff[1];
   assign mDevsel = ~ctl2_ff[0];

   always_comb begin
      nxt_state = state_ff;
      nxt_beat = beat_ff;
      nxt_blk = blk_ff;
      nxt_first = first_ff;
      nxt_gnt = 1'b1;
      nxt_st = gport_pkg::ST_RESET;
      nxt_frame = 1'b1; // Held deasserted outside pushed writes
      nxt_fOe = 1'b1;
      nxt_irdy = 1'b1;
      nxt_trdy = 1'b1;
      nxt_trdyOe = 1'b1;
      nxt_fw = 1'b0;
      nxt_done = 1'b0;
      nxt_abort = 1'b0;
      nxt_retry = 1'b0;
      case (state_ff)
         gport_pkg::S_IDLE: begin
            nxt_beat = 2'h0;
            nxt_blk = (xferBlocks == 4'h0) ? 4'h1 : xferBlocks;
            nxt_first = 1'b1;
            if (rdStart) begin
               nxt_gnt = 1'b0;
               nxt_st = hiPriority ? gport_pkg::ST_HP_READ : gport_pkg::ST_LP_READ;
               nxt_trdy = 1'b0; // First block trdy; short read gets just this one
               nxt_state = gport_pkg::S_RD_BLOCK;
            end else if (wrStart) begin
               nxt_gnt = 1'b0;
               nxt_st = hiPriority ? gport_pkg::ST_HP_WRITE : gport_pkg::ST_LP_WRITE;
               nxt_state = gport_pkg::S_WR_BLOCK;
            end else if (fwStart) begin
               nxt_gnt = 1'b0;
               nxt_st = gport_pkg::ST_START;
               nxt_fw = 1'b1;
               nxt_frame = 1'b0; // Frame only used for pushed writes
               nxt_state = gport_pkg::S_FW_WAIT;
            end
         end
         gport_pkg::S_RD_BLOCK: begin
            // Beats run without gaps inside the block master may not stall
            nxt_beat = beat_ff + 2'h1;
            if (beat_ff == 2'(gport_pkg::BLOCK_BEATS - 1)) begin
               nxt_blk = blk_ff - 4'h1;
               nxt_state = (blk_ff == 4'h1) ? gport_pkg::S_IDLE : gport_pkg::S_RD_WAIT;
               nxt_done = (blk_ff == 4'h1);
            end
         end
         gport_pkg::S_RD_WAIT: begin
            // Next block only when core ready and master irdy
            if (dataReady && mIrdy) begin
               nxt_trdy = 1'b0;
               nxt_state = gport_pkg::S_RD_BLOCK;
            end
         end
         gport_pkg::S_WR_BLOCK: begin
            // No frame relation is assumed; irdy alone starts the data
            if (mIrdy || beat_ff != 2'h0 || !first_ff) begin
               if (beat_ff == 2'h0) nxt_trdy = 1'b0; // Trdy per block
               nxt_first = 1'b0;
               // Master supplies every beat once irdy is seen
               nxt_beat = beat_ff + 2'h1;
               if (beat_ff == 2'(gport_pkg::BLOCK_BEATS - 1)) begin
                  nxt_blk = blk_ff - 4'h1;
                  if (blk_ff == 4'h1) begin
                     nxt_state = gport_pkg::S_IDLE;
                     nxt_done = 1'b1;
                  end
               end
            end
         end
         gport_pkg::S_FW_WAIT: begin
            nxt_fw = 1'b1;
            nxt_frame = mStop; // A termination releases frame at once
            // Pushed-write block starts when data ready and master trdy; the first block needs data ready only
            if (mStop) begin
               nxt_state = gport_pkg::S_FW_END;
               nxt_abort = 1'b1; // Disconnect or target-abort
               nxt_retry = ~mDevsel & first_ff; // Retry shape
            end else if (dataReady && (mTrdy || first_ff)) begin
               nxt_irdy = 1'b0;
               nxt_first = 1'b0;
               nxt_state = gport_pkg::S_FW_BLOCK;
            end
         end
         gport_pkg::S_FW_BLOCK: begin
            nxt_fw = 1'b1;
            nxt_irdy = 1'b0; // Valid every beat inside a block
            nxt_frame = (blk_ff == 4'h1) && (beat_ff >= 2'(gport_pkg::BLOCK_BEATS - 2));
            nxt_beat = beat_ff + 2'h1;
            if (mStop) begin
               nxt_irdy = 1'b1;
               nxt_frame = 1'b1;
               nxt_abort = 1'b1;
               nxt_state = gport_pkg::S_FW_END;
            end else if (beat_ff == 2'(gport_pkg::BLOCK_BEATS - 1)) begin
               nxt_irdy = 1'b1;
               nxt_blk = blk_ff - 4'h1;
               nxt_state = (blk_ff == 4'h1) ? gport_pkg::S_FW_END : gport_pkg::S_FW_WAIT;
               nxt_done = (blk_ff == 4'h1);
            end
         end
         gport_pkg::S_FW_END: begin
            nxt_state = gport_pkg::S_IDLE;
         end
         default: nxt_state = gport_pkg::S_IDLE;
      endcase
      // Stop is driven deasserted by the core except in pushed writes, where the master owns it
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= gport_pkg::S_IDLE;
         beat_ff <= 2'h0;
         blk_ff <= 4'h1;
         first_ff <= 1'b1;
         gnt_ff <= 1'b1;
         st_ff <= gport_pkg::ST_RESET;
         frame_ff <= 1'b1;
         fOe_ff <= 1'b1;
         irdy_ff <= 1'b1;
         trdy_ff <= 1'b1;
         trdyOe_ff <= 1'b1;
         fw_ff <= 1'b0;
         done_ff <= 1'b0;
         abort_ff <= 1'b0;
         retry_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         beat_ff <= nxt_beat;
         blk_ff <= nxt_blk;
         first_ff <= nxt_first;
         gnt_ff <= nxt_gnt;
         st_ff <= nxt_st;
         frame_ff <= nxt_frame;
         fOe_ff <= nxt_fOe;
         irdy_ff <= nxt_irdy;
         trdy_ff <= nxt_trdy;
         trdyOe_ff <= nxt_trdyOe;
         fw_ff <= nxt_fw;
         done_ff <= nxt_done;
         abort_ff <= nxt_abort;
         retry_ff <= nxt_retry;
      end
   end

   always_comb begin
      gntN = gnt_ff;
      arbiter_status_code = st_ff;
      frameOutN = frame_ff;
      frameOe = fOe_ff;
      irdyOutN = irdy_ff;
      irdyOe = fw_ff;
      trdyOutN = trdy_ff;
      trdyOe = trdyOe_ff & ~fw_ff; // Master owns trdy in pushed writes
      stopOutN = 1'b1;
      stopOe = ~fw_ff;
      pushed_write_mode = fw_ff;
      busy = (state_ff != gport_pkg::S_IDLE);
      xferDone = done_ff;
      xferAbort = abort_ff;
      retryError = retry_ff;
   end

   a_frame_idle_pipe: assert property (@(posedge ref_clk) disable iff (rst)
      !fw_ff |-> frame_ff) else $error("frame asserted outside pushed write");
   a_fw_irdy_block: assert property (@(posedge ref_clk) disable iff (rst)
      (state_ff == gport_pkg::S_FW_BLOCK) |-> (!irdy_ff && irdyOe))
      else $error("irdy gap in pushed block");
   a_rd_block_len: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(state_ff == gport_pkg::S_RD_BLOCK) |-> (state_ff == gport_pkg::S_RD_BLOCK)[*4])
      else $error("read block not four beats");
   a_stop_pipe: assert property (@(posedge ref_clk) disable iff (rst)
      (state_ff <= gport_pkg::S_WR_BLOCK) |-> (stopOe && stopOutN))
      else $error("stop not held in pipelined mode");
   a_status_start: assert property (@(posedge ref_clk) disable iff (rst)
      fwStart && state_ff == gport_pkg::S_IDLE && !rdStart && !wrStart
      |=> !gnt_ff && st_ff == gport_pkg::ST_START) else $error("bad start status");
   a_ovc_event: assert property (@(posedge ref_clk) disable iff (rst)
      (ovPrev_ff && !sync2_ff[2]) |=> overcurrentEvent) else $error("overcurrent missed");
   a_fw_stop_abort: assert property (@(posedge ref_clk) disable iff (rst)
      (state_ff inside {gport_pkg::S_FW_BLOCK, gport_pkg::S_FW_WAIT}) && mStop |=> xferAbort)
      else $error("stop ignored");
   a_rd_wait_trdy: assert property (@(posedge ref_clk) disable iff (rst)
      (state_ff == gport_pkg::S_RD_WAIT && !(dataReady && mIrdy)) |=> trdy_ff)
      else $error("trdy without master irdy");
endmodule
`default_nettype wire

/* File: sim/graphics_master_model.sv */
// Behavioural graphics master facing the core-logic controller
`timescale 1ns/1ps
`default_nettype none
module graphics_master_model (
   input wire logic ref_clk, // Bus clock
   input wire logic rst, // Reset, active high
   input wire logic pushedMode, // Core pushed-write indication
   input wire logic slow, // Insert waits between blocks
   input wire logic stopReq, // Request a disconnect
   input wire logic retryReq, // Illegal retry, retry test only
   output logic irdyN, // Master irdy value
   output logic trdyN, // Master trdy value
   output logic stopN, // Master stop value
   output logic devselN // Master devsel value
);
   logic [1:0] phase_ff;
   logic ready;
   // All pins change on the rising clock only; no idsel, lock or intc/intd pins exist
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end
   // Slow master is only used on reads and pushed writes; the core holds a block once
   // started, so idling here can only fall between blocks
   assign ready = !slow || (phase_ff != 2'h3);
   // Irdy ignores frame entirely; writes run with slow low so irdy never withdraws
   assign irdyN = pushedMode | ~ready;
   assign trdyN = ~(pushedMode & ready);
   // Unused lines are driven high by the model itself; no pull-ups are modelled
   assign stopN = ~(pushedMode & (stopReq | retryReq));
   assign devselN = ~(pushedMode & stopReq);
endmodule
`default_nettype wire

/* File: sim/graphics_port_block_flow_control_bench.sv */
// Self-checking bench for the core-logic flow controller
`timescale 1ns/1ps
`default_nettype none
module graphics_port_block_flow_control_bench;
   typedef struct {int kind; int blocks; logic hi; logic slw; logic [2:0] st;} row_type;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic rdStart = 0, wrStart = 0, fwStart = 0, hiPriority = 0, dataReady = 1;
   logic [3:0] xferBlocks = 4'h1;
   logic ovcN = 1, pmeN = 1, slow = 0, stopReq = 0, retryReq = 0;
   logic mIrdyN, mTrdyN, mStopN, mDevselN, irdyW, trdyW, stopW;
   logic gntN, frameN, frameOe, irdyN, irdyOe, trdyN, trdyOe, stopN, stopOe;
   logic pwMode, busy, done, abrt, retry, ovEv, pmeSeen;
   logic [2:0] status, gntSt;
   int fail_count = 0, checks_done = 0;
   int gntCnt, trdyCnt, irdyCnt, doneCnt, abrtCnt, retryCnt, ovCnt, badPipe, frameCnt;
   row_type rows[6] = '{'{0, 1, 0, 0, gport_pkg::ST_LP_READ}, '{0, 3, 1, 1, gport_pkg::ST_HP_READ},
      '{1, 1, 0, 0, gport_pkg::ST_LP_WRITE}, '{1, 2, 1, 0, gport_pkg::ST_HP_WRITE},
      '{2, 1, 0, 0, gport_pkg::ST_START}, '{2, 3, 0, 1, gport_pkg::ST_START}};
   always #20 ref_clk = ~ref_clk;
   // Irdy, trdy and stop each resolve to whichever party holds its enable; devsel comes from the master alone
   assign irdyW = irdyOe ? irdyN : mIrdyN;
   assign trdyW = trdyOe ? trdyN : mTrdyN;
   assign stopW = stopOe ? stopN : mStopN;
   gport_core_ctrl u_gport_core_ctrl (.ref_clk(ref_clk), .rst(rst), .rdStart(rdStart),
      .wrStart(wrStart), .fwStart(fwStart), .xferBlocks(xferBlocks), .hiPriority(hiPriority),
      .dataReady(dataReady), .irdyInN(irdyW), .trdyInN(trdyW), .stopInN(stopW),
      .devselInN(mDevselN), .monitor_overcurrent_n(ovcN), .pmeInN(pmeN), .gntN(gntN),
      .arbiter_status_code(status), .frameOutN(frameN), .frameOe(frameOe), .irdyOutN(irdyN),
      .irdyOe(irdyOe), .trdyOutN(trdyN), .trdyOe(trdyOe), .stopOutN(stopN), .stopOe(stopOe),
      .pushed_write_mode(pwMode), .busy(busy), .xferDone(done), .xferAbort(abrt),
      .retryError(retry), .overcurrentEvent(ovEv), .pmeSeen(pmeSeen));
   graphics_master_model u_graphics_master_model (.ref_clk(ref_clk), .rst(rst),
      .pushedMode(pwMode), .slow(slow), .stopReq(stopReq), .retryReq(retryReq),
      .irdyN(mIrdyN), .trdyN(mTrdyN), .stopN(mStopN), .devselN(mDevselN));
   always @(posedge ref_clk) begin
      if (gntN === 1'b0) begin
         gntCnt++;
         gntSt = status;
      end
      trdyCnt += (trdyOe === 1'b1 && trdyN === 1'b0);
      irdyCnt += (irdyOe === 1'b1 && irdyN === 1'b0);
      doneCnt += (done === 1'b1);
      abrtCnt += (abrt === 1'b1);
      retryCnt += (retry === 1'b1);
      ovCnt += (ovEv === 1'b1);
      frameCnt += (frameN === 1'b0 && irdyOe === 1'b1 && irdyN === 1'b0);
      // Frame must also be released by the cycle that reports the end
      badPipe += (pwMode !== 1'b1 && (frameN !== 1'b1 || stopN !== 1'b1))
         || ((done === 1'b1 || abrt === 1'b1) && frameN !== 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic clr;
      {gntCnt, trdyCnt, irdyCnt, doneCnt, abrtCnt, retryCnt, ovCnt, badPipe, frameCnt} = '0;
   endtask
   task automatic start(input int kind, input int blocks, input logic hi);
      @(posedge ref_clk);
      #1;
      xferBlocks = blocks[3:0];
      hiPriority = hi;
      rdStart = (kind == 0);
      wrStart = (kind == 1);
      fwStart = (kind == 2);
      @(posedge ref_clk);
      #1;
      {rdStart, wrStart, fwStart} = 3'h0;
   endtask
   task automatic finish;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 600) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n == 600) begin
         fail_count++;
         final_report();
      end
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      #1;
      chk("gnt_rst", gntN, 1'b1);
      chk("st_rst", status, gport_pkg::ST_RESET);
      chk("oe_rst", {frameOe, irdyOe, trdyOe, stopOe}, 4'hB);
      chk("pins_rst", {frameN, irdyN, trdyN, stopN}, 4'hF);
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      foreach (rows[i]) begin
         clr();
         slow = rows[i].slw;
         start(rows[i].kind, rows[i].blocks, rows[i].hi);
         chk("busy", busy, 1'b1);
         chk("pushed_mode", pwMode, rows[i].kind == 2);
         finish();
         chk("gnt_len", gntCnt, 1);
         chk("status", gntSt, rows[i].st);
         chk("trdy_blocks", trdyCnt, rows[i].kind < 2 ? rows[i].blocks : 0);
         chk("irdy_beats", irdyCnt, rows[i].kind == 2 ? 4 * rows[i].blocks : 0);
         chk("done", doneCnt, 1);
         chk("pipe_frame_stop", badPipe, 0);
         chk("frame_beats", frameCnt, rows[i].kind == 2 ? 4 * rows[i].blocks - 1 : 0);
         chk("no_term", abrtCnt + retryCnt, 0);
      end
      slow = 1'b0;
      clr();
      start(0, 2, 0);
      repeat (3) @(posedge ref_clk);
      start(1, 1, 0);
      finish();
      chk("refused_gnt", gntCnt, 1);
      chk("refused_done", doneCnt, 1);
      clr();
      start(2, 3, 0);
      repeat (8) @(posedge ref_clk);
      #1;
      stopReq = 1'b1;
      finish();
      stopReq = 1'b0;
      chk("disconnect", abrtCnt, 1);
      chk("disconnect_retry", retryCnt, 0);
      chk("term_frame", badPipe, 0);
      clr();
      dataReady = 1'b0;
      retryReq = 1'b1;
      start(2, 1, 0);
      repeat (8) @(posedge ref_clk);
      #1;
      chk("retry", retryCnt, 1);
      chk("retry_abort", abrtCnt, 1);
      retryReq = 1'b0;
      dataReady = 1'b1;
      finish();
      chk("retry_frame", badPipe, 0);
      // Reset in the middle of a pushed write must drop everything at once
      start(2, 2, 0);
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b1;
      #1;
      chk("rst_mid_busy", busy, 1'b0);
      chk("rst_mid_oe", {pwMode, frameOe, irdyOe, trdyOe, stopOe}, 5'h0B);
      chk("rst_mid_pins", {gntN, frameN, irdyN, trdyN, stopN}, 5'h1F);
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      clr();
      ovcN = 1'b0;
      pmeN = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("overcurrent", ovCnt, 1);
      chk("pme_low", pmeSeen, 1'b1);
      ovcN = 1'b1;
      pmeN = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("pme_high", pmeSeen, 1'b0);
      chk("overcurrent_rise", ovCnt, 1);
      final_report();
   end
endmodule
`default_nettype wire
